// >>> design/dspm_cfg.svh
// Purpose: constants of the multiplier input stage
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef DSPM_CFG_SVH
`define DSPM_CFG_SVH
// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define DSPM_SLICE_W   9
`define DSPM_SLICE_N   8
`define DSPM_PAIR_W    18
`define DSPM_WIDE_W    36
`define DSPM_DATA_W    72
`define DSPM_PROD_W    144
`define DSPM_CAS_W     18
`define DSPM_LANE_N    4
`define DSPM_SEL_W     16
// ----------------------------------------------------------------
// reset values and the full buffer count
// ----------------------------------------------------------------
`define DSPM_OPND_RST  9'h000
`define DSPM_PROD_RST  144'h0
`define DSPM_CNT_RST   2'h0
`define DSPM_BUF_FULL  2'h2
`endif

// >>> design/dspm_pkg.sv
// Purpose: types of the multiplier input stage
// Assumes: nothing
// Notes:   constants live in dspm_cfg.svh
package dspm_pkg;
  // arrangement of the eight slices
  typedef enum logic [1:0] {
    MODE_9X9,
    MODE_18X18,
    MODE_36X36
  } dspm_mode_type;
  typedef logic [8:0] dspm_slice_type;
endpackage

// >>> design/dspm_opnd_reg.sv
// Purpose: one 9-bit operand input register, parallel or chained load
// Assumes: tick, ena and clr already picked from the block-wide lanes
// Notes:   clear masks the output at once and empties the flop
`include "dspm_cfg.svh"
module dspm_opnd_reg (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     tick,
  input  wire logic                     ena,
  input  wire logic                     clr,
  input  wire logic                     shiftSel,
  input  wire dspm_pkg::dspm_slice_type parIn,
  input  wire dspm_pkg::dspm_slice_type chainIn,
  output dspm_pkg::dspm_slice_type      regOut,
  output logic                          loadPulse
);
  dspm_pkg::dspm_slice_type opnd_q;
  dspm_pkg::dspm_slice_type opnd_d;

  // load on the selected lane tick when enabled and not cleared
  assign loadPulse = tick & ena & ~clr;
  assign opnd_d    = shiftSel ? chainIn : parIn;
  // clear is forced onto the output so it acts without a tick
  assign regOut    = clr ? `DSPM_OPND_RST : opnd_q;

  // ----------------------------------------------------------------
  // operand flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst | clr) begin
      opnd_q <= `DSPM_OPND_RST;
    end else if (loadPulse) begin
      opnd_q <= opnd_d;
    end
  end

  AST_CLR_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    clr |-> (regOut == `DSPM_OPND_RST) ##1 (clr ||
      regOut == `DSPM_OPND_RST))
    else $error("cleared operand register not zero");
endmodule

// >>> design/dspm_mult_stage.sv
// Purpose: multiplier input stage of a configurable arithmetic block
// Assumes: lane ticks are one-cycle enables on clk from fabric dividers
// Notes:   products leave through a two-entry buffer with valid/ready
`include "dspm_cfg.svh"
module dspm_mult_stage (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire dspm_pkg::dspm_mode_type    mode,
  input  wire logic [`DSPM_DATA_W-1:0]    dataA,
  input  wire logic [`DSPM_DATA_W-1:0]    dataB,
  input  wire logic                       signA,
  input  wire logic                       signB,
  input  wire logic                       sharedSign,
  input  wire logic                       ctrlRegEn,
  input  wire logic [`DSPM_SLICE_N-1:0]   shiftEnA,
  input  wire logic [`DSPM_SLICE_N-1:0]   shiftEnB,
  input  wire logic [`DSPM_CAS_W-1:0]     cascadeInA,
  input  wire logic [`DSPM_CAS_W-1:0]     cascadeInB,
  input  wire logic [`DSPM_LANE_N-1:0]    laneTick,
  input  wire logic [`DSPM_LANE_N-1:0]    laneClr,
  input  wire logic [`DSPM_LANE_N-1:0]    laneEna,
  input  wire logic [`DSPM_SEL_W-1:0]     aClkSel,
  input  wire logic [`DSPM_SEL_W-1:0]     aClrSel,
  input  wire logic [`DSPM_SEL_W-1:0]     aEnaSel,
  input  wire logic [`DSPM_SEL_W-1:0]     bClkSel,
  input  wire logic [`DSPM_SEL_W-1:0]     bClrSel,
  input  wire logic [`DSPM_SEL_W-1:0]     bEnaSel,
  input  wire logic                       pipeEn,
  input  wire logic [1:0]                 pipeClkSel,
  input  wire logic [1:0]                 pipeClrSel,
  input  wire logic [1:0]                 pipeEnaSel,
  input  wire logic                       sendToAdder,
  input  wire logic                       adderReady,
  input  wire logic                       routeReady,
  output logic [`DSPM_CAS_W-1:0]          cascade_out_operand_a,
  output logic [`DSPM_CAS_W-1:0]          cascade_out_operand_b,
  output logic                            opReady,
  output logic                            adderValid,
  output logic                            routeValid,
  output logic [`DSPM_PROD_W-1:0]         prodOut,
  output logic                            signedResult,
  output logic                            narrowed36
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [`DSPM_DATA_W-1:0]  opData  [2];
  logic [`DSPM_CAS_W-1:0]   casIn   [2];
  logic [`DSPM_SLICE_N-1:0] shEn    [2];
  logic [`DSPM_SEL_W-1:0]   clkSel  [2];
  logic [`DSPM_SEL_W-1:0]   clrSel  [2];
  logic [`DSPM_SEL_W-1:0]   enaSel  [2];
  dspm_pkg::dspm_slice_type opQ     [2][`DSPM_SLICE_N];
  logic [`DSPM_SLICE_N-1:0] loadP   [2];
  logic [`DSPM_SLICE_N-1:0] clrNow  [2];
  logic [`DSPM_SLICE_N-1:0] shSel   [2];
  logic                     mode9;
  logic                     mode18;
  logic                     mode36;
  logic                     signA_q;
  logic                     signB_q;
  logic                     sA;
  logic                     sB;
  logic                     narrowA;
  logic                     narrowB;
  logic [`DSPM_WIDE_W-1:0]  wideA;
  logic [`DSPM_WIDE_W-1:0]  wideB;
  logic [71:0]              prodK   [`DSPM_SLICE_N];
  logic [`DSPM_PROD_W-1:0]  prodRaw;
  logic [`DSPM_PROD_W-1:0]  pipe_q;
  logic [`DSPM_PROD_W-1:0]  pipeOut;
  logic [`DSPM_PROD_W-1:0]  stageData;
  logic                     pipeClr;
  logic                     pipeLoad;
  logic                     trigger;
  logic                     fresh_q;
  logic [`DSPM_PROD_W-1:0]  buf_q   [2];
  logic                     wr_q;
  logic                     rd_q;
  logic [1:0]               cnt_q;
  logic [1:0]               cnt_d;
  logic                     outReady;
  logic                     bufValid;
  logic                     doPush;
  logic                     doPop;

  // full-precision 36x36 core, each side extended by its sign
  function automatic logic [71:0] dspm_mul(input logic [35:0] a,
                                           input logic [35:0] b,
                                           input logic        sa,
                                           input logic        sb);
    logic signed [36:0] ea;
    logic signed [36:0] eb;
    logic signed [73:0] pr;
    ea = {sa & a[35], a};
    eb = {sb & b[35], b};
    pr = ea * eb;
    return pr[71:0];
  endfunction

  // ----------------------------------------------------------------
  // operand side views, A is index 0 and B index 1
  // ----------------------------------------------------------------
  assign opData[0] = dataA;
  assign opData[1] = dataB;
  assign casIn[0]  = cascadeInA;
  assign casIn[1]  = cascadeInB;
  assign shEn[0]   = shiftEnA;
  assign shEn[1]   = shiftEnB;
  assign clkSel[0] = aClkSel;
  assign clkSel[1] = bClkSel;
  assign clrSel[0] = aClrSel;
  assign clrSel[1] = bClrSel;
  assign enaSel[0] = aEnaSel;
  assign enaSel[1] = bEnaSel;

  // one arrangement decoded from the mode
  assign mode9  = (mode == dspm_pkg::MODE_9X9);
  assign mode18 = (mode == dspm_pkg::MODE_18X18);
  assign mode36 = (mode == dspm_pkg::MODE_36X36);

  // ----------------------------------------------------------------
  // input registers and shift chain
  // ----------------------------------------------------------------
  for (genvar o = 0; o < 2; o++) begin : g_op
    for (genvar s = 0; s < `DSPM_SLICE_N; s++) begin : g_sl
      logic [2:0]               ci;
      logic [3:0]               si;
      dspm_pkg::dspm_slice_type chainIn;
      // pairs share the even slice's controls, 36x36 uses slice 0
      assign ci = mode9 ? 3'(s) : (mode18 ? 3'(s & 6) : 3'h0);
      assign si = {ci, 1'b0};
      assign clrNow[o][s] = laneClr[clrSel[o][si +: 2]];
      // either side may shift while the other loads in parallel
      assign shSel[o][s] = shEn[o][ci] & ~mode36;
      if (s == 0) begin : g_c0
        assign chainIn = casIn[o][8:0];
      end else if (s == 1) begin : g_c1
        assign chainIn = mode18 ? casIn[o][17:9] : opQ[o][0];
      end else begin : g_cn
        // a pair moves by two slices, a small multiplier by one
        assign chainIn = mode18 ? opQ[o][s-2] : opQ[o][s-1];
      end
      dspm_opnd_reg u_reg (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .tick      (laneTick[clkSel[o][si +: 2]]),
        .ena       (laneEna[enaSel[o][si +: 2]]),
        .clr       (clrNow[o][s]),
        .shiftSel  (shSel[o][s]),
        .parIn     (opData[o][s*9 +: 9]),
        .chainIn   (chainIn),
        .regOut    (opQ[o][s]),
        .loadPulse (loadP[o][s])
      );
    end
  end

  // last register of the chain drives the next block
  assign cascade_out_operand_a = mode18 ? {opQ[0][7], opQ[0][6]}
                                        : {9'h000, opQ[0][7]};
  assign cascade_out_operand_b = mode18 ? {opQ[1][7], opQ[1][6]}
                                        : {9'h000, opQ[1][7]};

  // ----------------------------------------------------------------
  // sign controls, raw or registered with their operand set
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst | clrNow[0][0]) begin
      signA_q <= 1'b0;
    end else if (loadP[0][0]) begin
      signA_q <= signA;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst | clrNow[1][0]) begin
      signB_q <= 1'b0;
    end else if (loadP[1][0]) begin
      signB_q <= signB;
    end
  end

  // one shared control lets both sides keep all 36 bits
  assign sA = ctrlRegEn ? signA_q : signA;
  assign sB = sharedSign ? sA : (ctrlRegEn ? signB_q : signB);
  assign signedResult = sA | sB;

  // mixed sign: the unsigned side loses its top bit
  assign narrowA = mode36 & ~sharedSign & ~sA & sB;
  assign narrowB = mode36 & ~sharedSign & sA & ~sB;
  assign narrowed36 = narrowA | narrowB;
  assign wideA = {opQ[0][3][8] & ~narrowA, opQ[0][3][7:0], opQ[0][2],
                  opQ[0][1], opQ[0][0]};
  assign wideB = {opQ[1][3][8] & ~narrowB, opQ[1][3][7:0], opQ[1][2],
                  opQ[1][1], opQ[1][0]};

  // ----------------------------------------------------------------
  // multipliers, operands sign-extended to the shared core width
  // ----------------------------------------------------------------
  for (genvar k = 0; k < `DSPM_SLICE_N; k++) begin : g_mul
    logic [35:0] ma;
    logic [35:0] mb;
    logic [35:0] pa;
    logic [35:0] pb;
    if (k < 4) begin : g_pair
      assign pa = {{18{sA & opQ[0][2*k+1][8]}}, opQ[0][2*k+1], opQ[0][2*k]};
      assign pb = {{18{sB & opQ[1][2*k+1][8]}}, opQ[1][2*k+1], opQ[1][2*k]};
    end else begin : g_nopair
      assign pa = 36'h0;
      assign pb = 36'h0;
    end
    // a sign-extended value multiplies to the same low product bits
    assign ma = mode9  ? {{27{sA & opQ[0][k][8]}}, opQ[0][k]} :
                mode18 ? pa : ((k == 0) ? wideA : 36'h0);
    assign mb = mode9  ? {{27{sB & opQ[1][k][8]}}, opQ[1][k]} :
                mode18 ? pb : ((k == 0) ? wideB : 36'h0);
    assign prodK[k] = dspm_mul(ma, mb, sA, sB);
  end

  // pack products by arrangement, each at full precision
  always_comb begin
    prodRaw = `DSPM_PROD_RST;
    unique case (mode)
      dspm_pkg::MODE_9X9: begin
        for (int k = 0; k < 8; k++) begin
          prodRaw[k*18 +: 18] = prodK[k][17:0];
        end
      end
      dspm_pkg::MODE_18X18: begin
        for (int k = 0; k < 4; k++) begin
          prodRaw[k*36 +: 36] = prodK[k][35:0];
        end
      end
      dspm_pkg::MODE_36X36: begin
        prodRaw[71:0] = prodK[0];
      end
      default: begin
        prodRaw = `DSPM_PROD_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pipeline register, stalled while the buffer cannot take a word
  // ----------------------------------------------------------------
  assign pipeClr  = laneClr[pipeClrSel];
  assign pipeLoad = pipeEn & laneTick[pipeClkSel] & laneEna[pipeEnaSel]
                    & ~pipeClr & opReady;
  assign pipeOut  = pipeClr ? `DSPM_PROD_RST : pipe_q;

  always_ff @(posedge clk) begin
    if (sys_rst | pipeClr) begin
      pipe_q <= `DSPM_PROD_RST;
    end else if (pipeLoad) begin
      pipe_q <= prodRaw;
    end
  end

  // the stage holds the packed product in every arrangement and is bypassed when pipeEn is low
  assign stageData = pipeEn ? pipeOut : prodRaw;
  assign trigger   = pipeEn ? pipeLoad : (loadP[0][0] | loadP[1][0]);

  // a fresh word exists one cycle after the stage that made it loaded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fresh_q <= 1'b0;
    end else begin
      fresh_q <= trigger;
    end
  end

  // ----------------------------------------------------------------
  // two-entry product buffer toward adder stage or routing
  // ----------------------------------------------------------------
  assign outReady   = sendToAdder ? adderReady : routeReady;
  assign bufValid   = (cnt_q != `DSPM_CNT_RST);
  assign adderValid = bufValid & sendToAdder;
  assign routeValid = bufValid & ~sendToAdder;
  assign doPop      = bufValid & outReady;
  assign doPush     = fresh_q & ((cnt_q != `DSPM_BUF_FULL) | doPop);
  // room is kept for the word already in flight
  assign opReady    = (cnt_q == `DSPM_CNT_RST) |
                      ((cnt_q == 2'h1) & doPop);
  assign prodOut    = buf_q[rd_q];
  assign cnt_d      = cnt_q + {1'b0, doPush} - {1'b0, doPop};

  always_ff @(posedge clk) begin
    if (doPush) begin
      buf_q[wr_q] <= stageData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= `DSPM_CNT_RST;
    end else begin
      wr_q  <= wr_q ^ doPush;
      rd_q  <= rd_q ^ doPop;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PAR_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    (loadP[0][0] && !shSel[0][0]) ##1 !clrNow[0][0] |->
      opQ[0][0] == $past(dataA[8:0]))
    else $error("parallel load did not take routing data");
  AST_CHAIN_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    (mode9 && loadP[0][2] && shSel[0][2]) ##1 (mode9 && !clrNow[0][2]) |->
      opQ[0][2] == $past(opQ[0][1]))
    else $error("shift chain did not move one slice");
  AST_CASCADE_OUT: assert property (@(posedge clk) disable iff (sys_rst)
    (mode18 && loadP[1][6] && shSel[1][6]) ##1 (mode18 && !clrNow[1][6]) |->
      cascade_out_operand_b[8:0] == $past(opQ[1][4]))
    else $error("cascade output not fed from chain");
  AST_NO_SHIFT_36: assert property (@(posedge clk) disable iff (sys_rst)
    (mode36 && loadP[1][1]) ##1 (mode36 && !clrNow[1][1]) |->
      opQ[1][1] == $past(dataB[17:9]))
    else $error("wide mode used the shift chain");
  AST_FULL_PREC: assert property (@(posedge clk) disable iff (sys_rst)
    (mode18 && !sA && !sB) |->
      prodRaw[35:0] == {opQ[0][1], opQ[0][0]} * {opQ[1][1], opQ[1][0]})
    else $error("unsigned pair product wrong");

  AST_SIGNED_RES: assert property (@(posedge clk) disable iff (sys_rst)
    (mode9 && sA && !sB) |-> prodRaw[17:0] ==
      {{9{opQ[0][0][8]}}, opQ[0][0]} * {9'h000, opQ[1][0]})
    else $error("mixed sign small product wrong");

  AST_PIPE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    pipeLoad ##1 (!pipeClr && pipeEn) |-> stageData == $past(prodRaw) &&
      fresh_q)
    else $error("pipeline word lost or late");

  AST_SIGN_REG: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrlRegEn && loadP[0][0]) ##1 (ctrlRegEn && !clrNow[0][0]) |->
      sA == $past(signA))
    else $error("registered sign not aligned with operand");

  AST_NARROW: assert property (@(posedge clk) disable iff (sys_rst)
    (mode36 && !sharedSign && !sA && sB) |-> !wideA[35] && narrowed36)
    else $error("unsigned side not cut to 35 bits");
endmodule

// >>> verification/dspm_fabric_sink.sv
// Purpose: fabric consumer of the product words
// Assumes: one word per rising edge with valid and ready high
// Notes:   hold parks ready low, stall makes it random
module dspm_fabric_sink (
  input  wire logic         clk,
  input  wire logic         hold,
  input  wire logic         stall,
  input  wire logic         valid,
  input  wire logic [143:0] data,
  output logic              ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [143:0] got[$];
  initial ready = 1'h1;
  // ready moves just after the sampling edge, so it is settled by mid-cycle
  always @(posedge clk) begin
    ready <= !hold && (!stall || ($urandom() % 3) != 0);
  end
  // words leave the stage towards the adder or general routing
  always @(posedge clk) begin
    if (valid === 1'h1 && ready === 1'h1) got.push_back(data);
  end
endmodule

// >>> verification/dspm_mult_stage_tb_top.sv
// Purpose: self-checking bench of the multiplier input stage
// Assumes: every select field points all slices at one lane
// Notes:   model keeps operand slices, expected words wait in a queue
module dspm_mult_stage_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // stimulus, wires and model state
  // ------
  logic         clk, sysRst, signA, signB, sharedSign, ctrlRegEn;
  logic         sendToAdder, hold, stall, sinkRdy, opReady, low, pipeEn;
  logic         adderValid, routeValid, signedResult, narrowed36, sgA, sgB;
  logic [71:0]  dataA, dataB;
  logic [7:0]   shiftEnA, shiftEnB;
  logic [17:0]  casInA, casInB, casOutA, casOutB;
  logic [3:0]   laneTick, laneClr, laneEna;
  logic [15:0]  aClk, aEna, bClk, bEna;
  logic [143:0] prodOut;
  logic [143:0] expQ[$];
  logic [8:0]   ra[8], rb[8];
  int           errorCnt = 0, cmpCount = 0;
  dspm_pkg::dspm_mode_type mode;
  // pipeline register only in the last test; lanes tick once per word
  dspm_mult_stage uut (.clk(clk), .sys_rst(sysRst), .mode(mode),
    .dataA(dataA), .dataB(dataB), .signA(signA), .signB(signB),
    .sharedSign(sharedSign), .ctrlRegEn(ctrlRegEn), .shiftEnA(shiftEnA),
    .shiftEnB(shiftEnB), .cascadeInA(casInA), .cascadeInB(casInB),
    .laneTick(laneTick), .laneClr(laneClr), .laneEna(laneEna),
    .aClkSel(aClk), .aClrSel(aClk), .aEnaSel(aEna), .bClkSel(bClk),
    .bClrSel(bClk), .bEnaSel(bEna), .pipeEn(pipeEn), .pipeClkSel(2'h0),
    .pipeClrSel(2'h0), .pipeEnaSel(2'h0), .sendToAdder(sendToAdder),
    .adderReady(sinkRdy & sendToAdder), .routeReady(sinkRdy & !sendToAdder),
    .cascade_out_operand_a(casOutA), .cascade_out_operand_b(casOutB),
    .opReady(opReady), .adderValid(adderValid), .routeValid(routeValid),
    .prodOut(prodOut), .signedResult(signedResult),
    .narrowed36(narrowed36));
  dspm_fabric_sink sink (.clk(clk), .hold(hold), .stall(stall),
    .valid(sendToAdder ? adderValid : routeValid), .data(prodOut),
    .ready(sinkRdy));
  // 200 MHz clock
  initial clk = 1'h0;
  always #2.5 clk = ~clk;
  // ------
  // helpers
  // ------
  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic printVerdict();
    $display("compares %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // full precision product, width 2w, sign per latched control
  function automatic logic [71:0] mul(logic [35:0] a, logic [35:0] b, int w);
    logic signed [73:0] x, y;
    x = {38'h0, a};
    y = {38'h0, b};
    if (sgA && a[w-1]) x = x - (74'sh1 <<< w);
    if (sgB && b[w-1]) y = y - (74'sh1 <<< w);
    return 72'(x * y);
  endfunction
  function automatic logic [143:0] expProd();
    logic [143:0] e;
    logic [71:0]  p;
    e = '0;
    for (int k = 0; k < 8; k++) begin
      p = mode == dspm_pkg::MODE_9X9 ? mul(36'(ra[k]), 36'(rb[k]), 9)
        : mul(36'({ra[k|1], ra[k&6]}), 36'({rb[k|1], rb[k&6]}), 18);
      if (mode == dspm_pkg::MODE_9X9) e[18*k+:18] = p[17:0];
      else e[36*(k/2)+:36] = p[35:0];
    end
    if (mode == dspm_pkg::MODE_36X36)
      e = {72'h0, mul({ra[3], ra[2], ra[1], ra[0]},
                      {rb[3], rb[2], rb[1], rb[0]}, 36)};
    return e;
  endfunction
  // upper half carries nothing in the wide arrangement
  function automatic logic [143:0] msk(logic [143:0] v);
    return mode == dspm_pkg::MODE_36X36 ? {72'h0, v[71:0]} : v;
  endfunction
  function automatic void upd(ref logic [8:0] r[8], input logic [71:0] d,
                              input logic [7:0] sh, input logic [17:0] cin);
    logic [8:0] o[8];
    int         st;
    o = r;
    st = mode == dspm_pkg::MODE_9X9 ? 1 : 2;
    for (int k = 0; k < 8; k++)
      if (mode == dspm_pkg::MODE_36X36 || !sh[st == 2 ? k & 6 : k])
        r[k] = d[9*k+:9];
      else
        r[k] = k < st ? cin[9*k+:9] : o[k-st];
  endfunction
  // one operand load; lane picks decide which side really loads
  task automatic load(input logic [3:0] tick, input logic [3:0] ena);
    int   n;
    logic la, lb, pl;
    n = 0;
    while (opReady !== 1'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      errorCnt++;
      printVerdict();
    end
    dataA = 72'({$urandom(), $urandom(), $urandom()});
    dataB = 72'({$urandom(), $urandom(), $urandom()});
    if (mode == dspm_pkg::MODE_36X36 && (signA ^ signB) && !sharedSign) begin
      dataA[35] = 1'h0;
      dataB[35] = 1'h0;
    end
    casInA = 18'($urandom());
    casInB = 18'($urandom());
    laneTick = tick;
    laneEna = ena;
    la = tick[aClk[1:0]] & ena[aEna[1:0]];
    lb = tick[bClk[1:0]] & ena[bEna[1:0]];
    // pipeline word holds the product of the operands before this edge
    pl = pipeEn & tick[0] & ena[0];
    if (pl) expQ.push_back(expProd());
    if (la) upd(ra, dataA, shiftEnA, casInA);
    if (lb) upd(rb, dataB, shiftEnB, casInB);
    if (la || !ctrlRegEn) sgA = signA;
    if (lb || !ctrlRegEn) sgB = sharedSign ? signA : signB;
    if (!pipeEn && (la || lb)) expQ.push_back(expProd());
    @(negedge clk);
    laneTick = 4'h0;
    if (mode != dspm_pkg::MODE_36X36) begin
      check(144'(casOutA), mode == 0 ? {9'h0, ra[7]} : {ra[7], ra[6]});
      check(144'(casOutB), mode == 0 ? {9'h0, rb[7]} : {rb[7], rb[6]});
    end
    if (!ctrlRegEn) begin
      check(144'(signedResult), 144'(sgA | sgB));
      check(144'(narrowed36), 144'(mode == 2 && sgA != sgB));
    end
  endtask
  // waits for every expected word, then compares in order
  task automatic drain(input string name);
    int n;
    n = 0;
    while (sink.got.size() < expQ.size() && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      errorCnt++;
      printVerdict();
    end
    check(144'(sink.got.size()), 144'(expQ.size()));
    while (expQ.size() > 0)
      check(msk(sink.got.pop_front()), msk(expQ.pop_front()));
    $display("test %s done, mismatches %0d", name, errorCnt);
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    void'($urandom(32'h9FE2DD1F));
    {sysRst, pipeEn} = 2'h2;
    mode = dspm_pkg::MODE_9X9;
    {signA, signB, sharedSign, ctrlRegEn, sendToAdder, hold, stall} = 7'h0;
    {dataA, dataB, casInA, casInB, shiftEnA, shiftEnB} = '0;
    {laneTick, laneClr, laneEna, aClk, aEna, bClk, bEna} = '0;
    for (int k = 0; k < 8; k++) {ra[k], rb[k]} = 18'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    check(144'({opReady, routeValid, adderValid}), 144'h4);
    sysRst = 1'h0;
    // every arrangement with every sign setting, consumer stalling
    stall = 1'h1;
    for (int m = 0; m < 3; m++) begin
      mode = dspm_pkg::dspm_mode_type'(m);
      shiftEnB = (m == 2) ? 8'hFF : 8'h00;
      for (int s = 0; s < 8; s++) begin
        {sharedSign, signB, signA} = 3'(s);
        sendToAdder = s[0];
        repeat (2) load(4'hF, 4'hF);
        @(negedge clk);
      end
      drain("modes");
    end
    // lanes picked apart per side; random ticks and enables
    mode = dspm_pkg::MODE_9X9;
    {sharedSign, shiftEnB, aClk, bEna} = {1'h0, 8'h00, 32'hAAAA5555};
    repeat (12) load(4'($urandom()), 4'($urandom()));
    @(negedge clk);
    drain("lanes");
    {aClk, bEna} = 32'h0;
    // registered signs keep the value of the load edge
    {ctrlRegEn, signA, signB} = 3'h7;
    load(4'hF, 4'hF);
    {signA, signB} = 2'h0;
    drain("ctrlreg");
    ctrlRegEn = 1'h0;
    // chains: A shifts with B parallel, then 18-bit B pairs shift
    shiftEnA = 8'hFF;
    repeat (10) load(4'hF, 4'hF);
    @(negedge clk);
    mode = dspm_pkg::MODE_18X18;
    {shiftEnA, shiftEnB} = 16'h0055;
    repeat (6) load(4'hF, 4'hF);
    drain("chain");
    shiftEnB = 8'h0;
    // clear masks the cascades at once and empties the registers
    laneClr = 4'h1;
    #1;
    check(144'({casOutA, casOutB}), 144'h0);
    @(negedge clk);
    laneClr = 4'h0;
    for (int k = 0; k < 8; k++) {ra[k], rb[k]} = 18'h0;
    bEna = 16'h5555;
    load(4'hF, 4'h1);
    drain("clear");
    bEna = 16'h0;
    // buffer filled against a parked consumer, then drained whole
    {hold, stall, low} = 3'h4;
    for (int i = 0; i < 6; i++)
      if (opReady === 1'h1) load(4'hF, 4'hF);
      else begin
        low = 1'h1;
        @(negedge clk);
      end
    check(144'(low), 144'h1);
    hold = 1'h0;
    drain("buffer");
    // pipeline register in the wide arrangement, consumer stalling
    mode = dspm_pkg::MODE_36X36;
    {pipeEn, stall} = 2'h3;
    repeat (4) load(4'hF, 4'hF);
    @(negedge clk);
    drain("pipe");
    printVerdict();
  end
endmodule
